// *** rtl/tsx_params.svh ***
// Command codes, timing counts and storage sizes of the trim sequence executor
`ifndef TSX_PARAMS_SVH
`define TSX_PARAMS_SVH

`define TSX_CMD_ON_FIRST    8'h81
`define TSX_CMD_ON_LAST     8'h94
`define TSX_CMD_OFF_FIRST   8'h98
`define TSX_CMD_OFF_LAST    8'hAB
`define TSX_CMD_OFF_SHIFT   8'h17
`define TSX_CMD_DLY_1MS     8'hB0
`define TSX_CMD_DLY_2MS     8'hB1
`define TSX_CMD_DLY_4MS     8'hB2
`define TSX_CMD_DLY_HALFS   8'hB3
`define TSX_CLK_HZ          10000000
`define TSX_TICK_MS         1
`define TSX_TICK_CYCLES     ((`TSX_CLK_HZ / 1000) * `TSX_TICK_MS)
`define TSX_HALFS_MS        500
`define TSX_UNIT_TICKS_1MS  1
`define TSX_UNIT_TICKS_2MS  2
`define TSX_UNIT_TICKS_4MS  4
`define TSX_PROG_BYTES      64
`define TSX_OUT_COUNT       20
`define TSX_OUTS_RESET      20'h00000

`endif

// *** rtl/tsx_pkg.sv ***
// Types shared by the trim sequence executor
package tsx_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic [5:0] addr;
        logic       we;
    } tsx_load_type;

    typedef struct packed {
        logic       pedalStep1;
        logic       hemDevice;
        logic       rollerLift;
        logic       emergencyStop;
        logic       endTacking;
        logic       trimming;
        logic       targetSpeed;
        logic       motorRunning;
        logic       needleDown;
        logic       needleUp;
        logic       rightLed;
        logic       leftLed;
        logic [7:0] solenoid;
    } tsx_outs_type;
endpackage

// *** rtl/tsx_prog_mem.sv ***
// Program byte store with registered read data
`timescale 1ns/10ps
module tsx_prog_mem #(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// *** rtl/tsx_executor.sv ***
// Trim sequence command executor: fetches program bytes and drives outputs
`timescale 1ns/10ps
`include "tsx_params.svh"

module tsx_executor #(
    parameter int TICK_CYCLES = `TSX_TICK_CYCLES,
    parameter int HALFS_TICKS = `TSX_HALFS_MS
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire tsx_pkg::tsx_load_type load,
    input  wire logic                  start,
    output tsx_pkg::tsx_outs_type      outs,
    output logic                       busy,
    output logic                       badCmd
);
    import tsx_pkg::*;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rstMeta;
    logic rstSync;

    // Asserts at once, releases on the clock so no step starts half reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ************************************************************
    // Program store
    // ************************************************************
    logic [5:0] pc;
    logic [7:0] memData;

    // Loading during a run may change bytes mid-step
    // Loader stays within 64 bytes: address is only six bits wide
    tsx_prog_mem #(
        .DEPTH (`TSX_PROG_BYTES),
        .AW    (6)
    ) u_mem (
        .clk   (clk),
        .we    (load.we),
        .waddr (load.addr),
        .wdata (load.data),
        .raddr (pc),
        .rdata (memData)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Registered read costs a fetch cycle before every byte is decoded
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_DECODE,
        ST_DFETCH,
        ST_DATA,
        ST_WAIT
    } tsx_state_type;

    tsx_state_type state;
    tsx_state_type next_state;
    logic [5:0]    next_pc;
    logic [19:0]   outBits;
    logic [19:0]   next_outBits;
    logic [1:0]    unitSel;
    logic [1:0]    next_unitSel;
    logic [7:0]    units;
    logic [7:0]    next_units;
    logic [9:0]    subTicks;
    logic [9:0]    next_subTicks;
    logic [23:0]   cycles;
    logic [23:0]   next_cycles;
    logic          next_badCmd;
    logic [9:0]    ticksPerUnit;
    logic [7:0]    offIdx;

    // Millisecond ticks in one unit of each delay code
    always_comb begin
        case (unitSel)
            2'd0:    ticksPerUnit = 10'(`TSX_UNIT_TICKS_1MS);
            2'd1:    ticksPerUnit = 10'(`TSX_UNIT_TICKS_2MS);
            2'd2:    ticksPerUnit = 10'(`TSX_UNIT_TICKS_4MS);
            default: ticksPerUnit = 10'(HALFS_TICKS);
        endcase
    end

    always_comb begin
        next_state    = state;
        next_pc       = pc;
        next_outBits  = outBits;
        next_unitSel  = unitSel;
        next_units    = units;
        next_subTicks = subTicks;
        next_cycles   = cycles;
        next_badCmd   = badCmd;
        offIdx        = memData - `TSX_CMD_OFF_FIRST;
        case (state)
            // Start is only taken here, so it is ignored during a run
            ST_IDLE: begin
                if (start) begin
                    next_pc     = 6'h00;
                    next_badCmd = 1'b0;
                    next_state  = ST_FETCH;
                end
            end
            // Read data arrives one cycle after the address is set
            ST_FETCH: begin
                next_state = ST_DECODE;
            end
            // Every decoded step advances pc by one
            ST_DECODE: begin
                next_pc    = pc + 6'd1;
                next_state = ST_FETCH;
                if (memData >= `TSX_CMD_ON_FIRST && memData <= `TSX_CMD_ON_LAST) begin
                    // Includes status lines 8BH..91H and pedal step 94H
                    next_outBits[5'(memData - `TSX_CMD_ON_FIRST)] = 1'b1;
                end else if (memData >= `TSX_CMD_OFF_FIRST
                             && memData <= `TSX_CMD_OFF_LAST) begin
                    // Same bit as the on code 17H lower
                    next_outBits[5'(offIdx)] = 1'b0;
                end else if (memData >= `TSX_CMD_DLY_1MS
                             && memData <= `TSX_CMD_DLY_HALFS) begin
                    next_unitSel = memData[1:0];
                    next_state   = ST_DFETCH;
                end else begin
                    // Unknown or out-of-scope code ends the sequence
                    next_badCmd = 1'b1;
                    next_state  = ST_IDLE;
                end
                // No end code exists: the last address closes the run unless it holds a delay code, whose count is then read from address 0
                if (pc == 6'd63 && next_state == ST_FETCH) begin
                    next_state = ST_IDLE;
                end
            end
            // Read data still holds the command byte here; wait one cycle
            ST_DFETCH: begin
                next_state = ST_DATA;
            end
            ST_DATA: begin
                // One data byte follows a delay command
                // A zero count finishes at once; memData is the data byte here
                next_units    = memData;
                next_subTicks = 10'd0;
                next_cycles   = 24'd0;
                next_state    = ST_WAIT;
                next_pc       = pc + 6'd1;
            end
            // Cycles per tick, then ticks per unit, then units count down
            ST_WAIT: begin
                if (cycles == 24'd0 && subTicks == 10'd0 && units == 8'd0) begin
                    next_state = (pc == 6'd0) ? ST_IDLE : ST_FETCH;
                end else if (cycles != 24'd0) begin
                    next_cycles = cycles - 24'd1;
                end else begin
                    next_cycles = 24'(TICK_CYCLES - 1);
                    if (subTicks != 10'd0) begin
                        next_subTicks = subTicks - 10'd1;
                    end else begin
                        next_units    = units - 8'd1;
                        next_subTicks = ticksPerUnit - 10'd1;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            state    <= ST_IDLE;
            pc       <= 6'h00;
            outBits  <= `TSX_OUTS_RESET;
            unitSel  <= 2'd0;
            units    <= 8'h00;
            subTicks <= 10'h000;
            cycles   <= 24'h000000;
            badCmd   <= 1'b0;
        end else begin
            state    <= next_state;
            pc       <= next_pc;
            outBits  <= next_outBits;
            unitSel  <= next_unitSel;
            units    <= next_units;
            subTicks <= next_subTicks;
            cycles   <= next_cycles;
            badCmd   <= next_badCmd;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Busy registered so every output is a flip-flop
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            busy <= 1'b0;
        end else begin
            busy <= (next_state != ST_IDLE);
        end
    end

    // Levels stay after a run ends; only off codes or reset clear them
    assign outs = tsx_outs_type'(outBits);
endmodule

// *** tb/tsx_executor_sva.sv ***
// Port checker for the trim sequence executor
`timescale 1ns/10ps
module tsx_executor_sva (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire tsx_pkg::tsx_load_type load,
    input wire logic                  start,
    input wire tsx_pkg::tsx_outs_type outs,
    input wire logic                  busy,
    input wire logic                  badCmd
);
    import tsx_pkg::*;
    // ************************************
    // Assertions
    // ************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_SINGLE_CHANGE: assert property ($onehot0(outs ^ $past(outs)))
        else $error("more than one output line changed");
    AST_QUIET_IDLE: assert property (!busy && !$past(busy) && !$past(busy, 2) |-> $stable(outs))
        else $error("outputs moved while idle");
    AST_PEDAL_ALONE: assert property ($changed(outs.pedalStep1) |-> $stable(outs[18:0]))
        else $error("pedal step change disturbed other lines");
    AST_STEP_SPACING: assert property ($changed(outs) |=> $stable(outs))
        else $error("outputs changed on consecutive cycles");
    AST_BAD_ENDS: assert property ($rose(badCmd) |-> ##[0:2] !busy)
        else $error("unknown code did not end the run");
    AST_START_BUSY: assert property (start && !busy |-> ##[1:3] busy)
        else $error("start while idle did not begin a run");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(start) || $past(start, 2))
        else $error("run began without start");
    AST_BAD_CLEAR: assert property ($fell(badCmd) |-> $past(start) || $past(start, 2))
        else $error("bad command flag cleared without start");
    cover property ($rose(badCmd));
    cover property ($rose(outs.pedalStep1));
    cover property ($fell(busy));
    cover property ($fell(busy) && !badCmd);
endmodule

bind tsx_executor tsx_executor_sva tsx_executor_sva_i (
    .clk(clk), .rst_n(rst_n), .load(load), .start(start),
    .outs(outs), .busy(busy), .badCmd(badCmd)
);

// *** tb/tsx_line_model.sv ***
// Model of the solenoid, lamp and status lines
`timescale 1ns/10ps
module tsx_line_model (
    input wire logic                  clk,
    input wire tsx_pkg::tsx_outs_type outs,
    output logic                      lineEdge
);
    import tsx_pkg::*;
    tsx_outs_type held;
    // Lines only latch levels, so a change is reported at once and clears on the next edge
    always_ff @(posedge clk) begin
        held <= outs;
    end
    assign lineEdge = (outs != held);
endmodule

// *** tb/tsx_executor_test.sv ***
// Testbench of the trim sequence executor
`timescale 1ns/10ps
`include "tsx_params.svh"
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp); end end
module tsx_executor_test;
    import tsx_pkg::*;
    // ************************************
    // Bench
    // ************************************
    // Short counts keep delay runs brief
    localparam int TICK  = 2;
    localparam int HALFS = 3;
    logic         clk;
    logic         rst_n;
    tsx_load_type load;
    logic         start;
    tsx_outs_type outs;
    logic         busy;
    logic         badCmd;
    logic         lineEdge;
    logic [19:0]  expOuts;
    int           miscompares;
    int           checks;
    int           base;
    int           cyc;
    int           units[4];

    tsx_executor #(.TICK_CYCLES(TICK), .HALFS_TICKS(HALFS)) tsx_executor_i (
        .clk(clk), .rst_n(rst_n), .load(load), .start(start),
        .outs(outs), .busy(busy), .badCmd(badCmd));
    tsx_line_model tsx_line_model_i (.clk(clk), .outs(outs), .lineEdge(lineEdge));

    always #50 clk = ~clk;

    task automatic complete_run();
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Six bytes from address 0; we stays high across them
    task automatic load_prog(input logic [47:0] prog);
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            load <= '{data: prog[47-8*i -: 8], addr: 6'(i), we: 1'b1};
            @(posedge clk);
        end
        load.we <= 1'b0;
    endtask

    // Returns cycles from start to the first line change; samples on the falling edge
    task automatic run_prog(output int first, input logic expBad);
        int n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        first = 0;
        n = 0;
        while (n < 2000 && (n < 4 || busy !== 1'b0)) begin
            @(negedge clk);
            n++;
            if (lineEdge === 1'b1 && first == 0) first = n;
        end
        if (n >= 2000) miscompares++;
        repeat (3) @(negedge clk);
        `CHK(badCmd, expBad)
        `CHK(busy, 1'b0)
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        load = '0;
        start = 1'b0;
        miscompares = 0;
        checks = 0;
        expOuts = '0;
        units = '{1, 2, 4, HALFS};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(negedge clk);
        `CHK(outs, 20'h00000)
        `CHK(busy, 1'b0)
        for (int k = 0; k < 20; k++) begin
            load_prog({8'h81 + 8'(k), 40'h0});
            run_prog(cyc, 1'b1);
            expOuts[k] = 1'b1;
            `CHK(outs, expOuts)
        end
        for (int k = 0; k < 20; k++) begin
            load_prog({8'h98 + 8'(k), 40'h0});
            run_prog(cyc, 1'b1);
            expOuts[k] = 1'b0;
            `CHK(outs, expOuts)
        end
        load_prog(48'h81_82_98_00_00_00);
        run_prog(cyc, 1'b1);
        `CHK(outs, 20'h00002)
        load_prog(48'h99_00_00_00_00_00);
        run_prog(cyc, 1'b1);
        `CHK(outs, 20'h00000)
        // Overhead cancels out by comparing against a zero count
        for (int j = 0; j < 4; j++) begin
            load_prog({8'hB0 + 8'(j), 40'h00_81_98_00_00});
            run_prog(base, 1'b1);
            load_prog({8'hB0 + 8'(j), 40'h03_81_98_00_00});
            run_prog(cyc, 1'b1);
            `CHK(cyc - base, 3 * units[j] * TICK)
            `CHK(outs, 20'h00000)
        end
        // No stop code: the run ends after the last address
        @(posedge clk);
        for (int a = 0; a < `TSX_PROG_BYTES; a++) begin
            load <= '{data: (a == 63) ? 8'h8A : 8'hA1, addr: 6'(a), we: 1'b1};
            @(posedge clk);
        end
        load.we <= 1'b0;
        run_prog(cyc, 1'b0);
        `CHK(outs, 20'h00200)
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
endmodule
